/* bench/fpa_regfile_model.sv */
// wishbone master model standing for the register file and instruction decoder
`timescale 1ns/1ps

module fpa_regfile_model (
  // clock
  input  wire logic        clk_i,
  // wishbone master side
  output logic             cyc_o,
  output logic             stb_o,
  output logic             we_o,
  output logic      [7:0]  adr_o,
  output logic      [3:0]  sel_o,
  output logic      [31:0] dat_o,
  input  wire logic [31:0] dat_i,
  input  wire logic        ack_i,
  // dispatch pulses toward the other units
  input  wire logic        mul_req_i,
  input  wire logic        shf_req_i
);
  int mul_cnt = 0;
  int shf_cnt = 0;

  // idle bus at time zero
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o  = 1'b0;
    adr_o = 8'h00;
    sel_o = 4'h0;
    dat_o = 32'h00000000;
  end

  // count one-cycle dispatch pulses, so a stuck pulse shows as a wrong count
  always @(posedge clk_i) begin
    if (mul_req_i === 1'b1) mul_cnt <= mul_cnt + 1;
    if (shf_req_i === 1'b1) shf_cnt <= shf_cnt + 1;
  end

  // one classic cycle; released lines show the inverse so stale values cannot pass
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o  <= w;
    adr_o <= a;
    sel_o <= 4'hF;
    dat_o <= d;
    // no cycle count is assumed; only the bench timeout ends a lost ack
    do begin
      @(posedge clk_i);
    end while (ack_i !== 1'b1);
    q = dat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    we_o  <= ~w;
    adr_o <= ~a;
    sel_o <= 4'h0;
    dat_o <= ~d;
  endtask : xfer
endmodule : fpa_regfile_model

/* bench/tb.sv */
// self-checking bench for the fixed-point alu unit
`timescale 1ns/1ps
`include "fpa_params.svh"

module tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc, stb, we, ack, mul_req, shf_req;
  logic [7:0] adr, unit_op;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, exp_res, q;
  int error_cnt = 0;
  int n_checks = 0;
  int cyc_cnt = 0;
  int m0, s0;
  localparam logic [7:0] OPS [20] = '{`FPA_OP_ADD, `FPA_OP_SUB, `FPA_OP_ADDC, `FPA_OP_SUBB,
    `FPA_OP_AVG, `FPA_OP_COMP, `FPA_OP_PASS, `FPA_OP_NEG, `FPA_OP_XCI, `FPA_OP_XCIM,
    `FPA_OP_INC, `FPA_OP_DEC, `FPA_OP_AND, `FPA_OP_OR, `FPA_OP_XOR, `FPA_OP_NOT,
    `FPA_OP_MIN, `FPA_OP_MAX, `FPA_OP_CLIP, `FPA_OP_ABS};

  always #5 clk_i = ~clk_i;

  fpa_top fpa_top_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
    .mul_req_o(mul_req), .shf_req_o(shf_req), .unit_op_o(unit_op));

  fpa_regfile_model fpa_regfile_model_i (.clk_i(clk_i), .cyc_o(cyc), .stb_o(stb), .we_o(we),
    .adr_o(adr), .sel_o(sel), .dat_o(wdat), .dat_i(rdat), .ack_i(ack),
    .mul_req_i(mul_req), .shf_req_i(shf_req));

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test

  // a hang is cut short well above the few thousand cycles the run needs
  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 30000) begin
      error_cnt++;
      end_of_test();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    fpa_regfile_model_i.xfer(1'b1, a, d, r);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    fpa_regfile_model_i.xfer(1'b0, a, 32'h00000000, d);
  endtask : rd

  // reference: {value, zero, neg, ovf, carry}; adder ops share one 33-bit sum
  function automatic logic [35:0] ref_alu(input logic [7:0] op, input logic [31:0] x,
      input logic [31:0] y, input logic c, input logic sat, input logic rnd);
    logic [31:0] a, b, v;
    logic ci, ar, vf, cf;
    logic [32:0] s;
    a = x;
    b = y;
    ci = 1'b0;
    ar = 1'b1;
    vf = 1'b0;
    cf = 1'b0;
    case (op)
      `FPA_OP_ADD: ar = 1'b1;
      `FPA_OP_SUB: begin b = ~y; ci = 1'b1; end
      `FPA_OP_ADDC: ci = c;
      `FPA_OP_SUBB: begin b = ~y; ci = c; end
      `FPA_OP_XCI: begin b = 32'h00000000; ci = c; end
      `FPA_OP_XCIM: begin b = 32'hFFFFFFFF; ci = c; end
      `FPA_OP_INC: begin b = 32'h00000000; ci = 1'b1; end
      `FPA_OP_DEC: b = 32'hFFFFFFFF;
      `FPA_OP_NEG: begin a = 32'h00000000; b = ~x; ci = 1'b1; end
      `FPA_OP_ABS: begin a = 32'h00000000; b = x[31] ? ~x : x; ci = x[31]; end
      default: ar = 1'b0;
    endcase
    s = {1'b0, a} + {1'b0, b} + {32'h00000000, ci};
    v = s[31:0];
    if (ar) begin
      cf = s[32];
      vf = (a[31] == b[31]) && (v[31] != a[31]);
      if (sat && vf) v = a[31] ? `FPA_MIN_NEG : `FPA_MAX_POS;
    end
    case (op)
      `FPA_OP_AVG: begin v = s[32:1] + {31'h0, rnd & s[0]}; cf = s[32]; end
      `FPA_OP_PASS: v = x;
      `FPA_OP_AND: v = x & y;
      `FPA_OP_OR: v = x | y;
      `FPA_OP_XOR: v = x ^ y;
      `FPA_OP_NOT: v = ~x;
      `FPA_OP_MIN: v = ($signed(x) < $signed(y)) ? x : y;
      `FPA_OP_MAX: v = ($signed(x) > $signed(y)) ? x : y;
      `FPA_OP_CLIP: v = ($signed(x) > $signed(y)) ? y : ($signed(x) < -$signed(y)) ? -y : x;
      `FPA_OP_COMP: return {32'h0, x == y, $signed(x) < $signed(y), 2'b00};
      default: v = v;
    endcase
    return {v, v == 32'h0, v[31], vf, cf};
  endfunction : ref_alu

  // one alu command with random history, carry and mode preloaded
  task automatic do_op(input logic [7:0] op, input logic [31:0] x, input logic [31:0] y,
      input logic c, input logic sat, input logic rnd);
    logic [35:0] e;
    logic [31:0] d;
    logic [7:0] h;
    h = $urandom;
    e = ref_alu(op, x, y, c, sat, rnd);
    wr(`FPA_OFS_XOP, x);
    wr(`FPA_OFS_YOP, y);
    wr(`FPA_OFS_MODE, {30'h0, sat, rnd});
    wr(`FPA_OFS_STAT, {h, 17'h0, 3'b111, c, 3'b000});
    wr(`FPA_OFS_EXT, 32'h000000FF);
    wr(`FPA_OFS_CMD, {22'h0, `FPA_CU_ALU, op});
    if (op == `FPA_OP_COMP) h = {~e[3] & ~e[2], h[7:1]};
    else exp_res = e[35:4];
    rd(`FPA_OFS_RES, d);
    chk("result", exp_res, d);
    rd(`FPA_OFS_EXT, d);
    chk("extension", (op == `FPA_OP_COMP) ? 32'hFF : 32'h0, d);
    rd(`FPA_OFS_STAT, d);
    chk("status", {h, 20'h0, e[0], e[2], e[1], e[3]}, d);
  endtask : do_op

  function automatic logic [31:0] pick();
    case ($urandom % 5)
      0: return `FPA_MAX_POS;
      1: return `FPA_MIN_NEG;
      2: return {31'h0, 1'($urandom)};
      3: return 32'hFFFFFFFF;
      default: return $urandom;
    endcase
  endfunction : pick

  initial begin
    logic [7:0] op, a;
    logic [31:0] x, y;
    $urandom(32'hc839c72b);
    exp_res = 32'h0;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    // reset values, write-only command and an unmapped word all read zero
    wr(8'h1C, 32'hFFFFFFFF);
    for (int i = 0; i < 8; i++) begin
      a = 8'(i * 4);
      rd(a, q);
      chk("reset word", 32'h0, q);
    end
    $display("test reset done");
    // saturation corners and an equal subtract by hand, then random commands
    do_op(`FPA_OP_ADD, `FPA_MAX_POS, 32'h1, 1'b0, 1'b1, 1'b0);
    do_op(`FPA_OP_SUB, `FPA_MIN_NEG, 32'h1, 1'b0, 1'b1, 1'b0);
    do_op(`FPA_OP_SUB, 32'h5, 32'h5, 1'b1, 1'b0, 1'b0);
    for (int i = 0; i < 160; i++) begin
      op = OPS[i % 20];
      x = pick();
      y = pick();
      if (op == `FPA_OP_AVG) x = x & 32'h0FFFFFFF;
      if (op == `FPA_OP_AVG || op == `FPA_OP_CLIP) y = y & 32'h0FFFFFFF;
      do_op(op, x, y, 1'($urandom), 1'($urandom), 1'($urandom));
    end
    $display("test alu done");
    // unit select routes to alu, multiplier or shifter
    wr(`FPA_OFS_XOP, 32'h12345678);
    for (int cu = 0; cu < 3; cu++) begin
      op = (cu == 0) ? `FPA_OP_PASS : 8'($urandom);
      m0 = fpa_regfile_model_i.mul_cnt;
      s0 = fpa_regfile_model_i.shf_cnt;
      wr(`FPA_OFS_CMD, {22'h0, 2'(cu), op});
      @(posedge clk_i);
      if (cu == 0) exp_res = 32'h12345678;
      chk("mul pulses", 32'(m0 + (cu == 1)), 32'(fpa_regfile_model_i.mul_cnt));
      chk("shf pulses", 32'(s0 + (cu == 2)), 32'(fpa_regfile_model_i.shf_cnt));
      chk("unit op", {24'h0, op}, {24'h0, unit_op});
      rd(`FPA_OFS_RES, q);
      chk("result", exp_res, q);
    end
    $display("test dispatch done");
    // a floating-point code is refused: reject set, flags and result kept
    wr(`FPA_OFS_STAT, 32'h00000005);
    wr(`FPA_OFS_CMD, 32'h00000081);
    rd(`FPA_OFS_STAT, q);
    chk("reject status", 32'h00000105, q);
    rd(`FPA_OFS_RES, q);
    chk("result", exp_res, q);
    $display("test reject done");
    end_of_test();
  end
endmodule : tb

/* rtl/fpa_core.sv */
// combinational fixed-point alu datapath
`timescale 1ns/1ps
`include "fpa_params.svh"

module fpa_core (
  // operands and operation
  input  wire logic [7:0]          op_i,
  input  wire logic [31:0]         x_i,
  input  wire logic [31:0]         y_i,
  // mode and current carry
  input  wire logic                sat_i,
  input  wire logic                rnd_i,
  input  wire logic                carry_i,
  // answer
  output fpa_pkg::fpa_result_t     res_o
);
  import fpa_pkg::*;

  logic [32:0] sum;
  logic [31:0] a;
  logic [31:0] b;
  logic        cin;
  logic        c31;
  logic        arith;
  logic        avg;
  logic        hi_pos;
  logic        hi_neg;
  logic        lt;
  logic [31:0] wrap;
  logic [32:0] avg_full;

  // operand steering for the shared adder; subtract is x + ~y + 1
  always_comb begin
    a     = x_i;
    b     = y_i;
    cin   = 1'b0;
    arith = 1'b1;
    avg   = 1'b0;
    unique case (op_i)
      `FPA_OP_ADD:  b = y_i;
      `FPA_OP_SUB:  begin b = ~y_i; cin = 1'b1; end
      `FPA_OP_ADDC: cin = carry_i;
      `FPA_OP_SUBB: begin b = ~y_i; cin = carry_i; end
      `FPA_OP_AVG:  avg = 1'b1;
      `FPA_OP_COMP: begin b = ~y_i; cin = 1'b1; end
      `FPA_OP_XCI:  begin b = 32'h00000000; cin = carry_i; end
      `FPA_OP_XCIM: begin b = 32'hFFFFFFFF; cin = carry_i; end
      `FPA_OP_INC:  begin b = 32'h00000000; cin = 1'b1; end
      `FPA_OP_DEC:  b = 32'hFFFFFFFF;
      `FPA_OP_NEG:  begin a = 32'h00000000; b = ~x_i; cin = 1'b1; end
      `FPA_OP_ABS:  begin
        a   = 32'h00000000;
        b   = x_i[31] ? ~x_i : x_i;
        cin = x_i[31];
      end
      // min, max and clip borrow the subtractor only for the signed order test
      `FPA_OP_MIN, `FPA_OP_MAX, `FPA_OP_CLIP: begin
        b     = ~y_i;
        cin   = 1'b1;
        arith = 1'b0;
      end
      default:      arith = 1'b0;
    endcase
  end

  // carries out of the top two stages give carry and overflow
  assign sum = {1'b0, a} + {1'b0, b} + {32'h00000000, cin};
  assign c31 = a[31] ^ b[31] ^ sum[31];
  assign hi_pos = ~sum[32] & c31 & ~a[31]; // positive wrap
  assign hi_neg = sum[32] & ~c31 & a[31];  // negative wrap
  assign wrap   = sum[31:0];
  // signed compare from the subtractor: negative xor overflow
  assign lt = sum[31] ^ (sum[32] ^ c31);
  // average keeps a 33rd bit so the halving never wraps
  assign avg_full = {x_i[31], x_i} + {y_i[31], y_i}
                    + {32'h00000000, rnd_i & (x_i[0] ^ y_i[0])};

  // result select, saturation and flags per code
  always_comb begin
    res_o = '0;
    res_o.writes = 1'b1;
    res_o.legal  = 1'b1;
    if (arith && !avg && op_i != `FPA_OP_COMP) begin
      res_o.value = wrap;
      if (sat_i && hi_pos) res_o.value = `FPA_MAX_POS;
      else if (sat_i && hi_neg) res_o.value = `FPA_MIN_NEG;
      res_o.flags.ovf   = sum[32] ^ c31;
      res_o.flags.carry = sum[32];
    end else begin
      unique case (op_i)
        `FPA_OP_AVG: begin
          res_o.value       = avg_full[32:1];
          res_o.flags.carry = sum[32];
        end
        `FPA_OP_COMP: begin
          res_o.writes  = 1'b0;
          res_o.compare = 1'b1;
        end
        `FPA_OP_PASS: res_o.value = x_i;
        `FPA_OP_AND:  res_o.value = x_i & y_i;
        `FPA_OP_OR:   res_o.value = x_i | y_i;
        `FPA_OP_XOR:  res_o.value = x_i ^ y_i;
        `FPA_OP_NOT:  res_o.value = ~x_i;
        `FPA_OP_MIN:  res_o.value = lt ? x_i : y_i;
        `FPA_OP_MAX:  res_o.value = lt ? y_i : x_i;
        `FPA_OP_CLIP: begin
          if (!x_i[31]) res_o.value = (lt || x_i == y_i) ? x_i : y_i;
          else          res_o.value = ($signed(x_i) < -$signed(y_i)) ? -y_i : x_i;
        end
        default: begin
          res_o.writes = 1'b0;
          res_o.legal  = 1'b0;
        end
      endcase
    end
    // compare flags come from the operands, all others from the output
    if (op_i == `FPA_OP_COMP) begin
      res_o.flags.zero = (x_i == y_i);
      res_o.flags.neg  = lt;
    end else begin
      res_o.flags.zero = (res_o.value == 32'h00000000);
      res_o.flags.neg  = res_o.value[31];
    end
  end

endmodule : fpa_core

/* rtl/fpa_params.svh */
// constants for the fixed-point alu unit: offsets, field positions, codes and reset values
`ifndef FPA_PARAMS_SVH
`define FPA_PARAMS_SVH

// register offsets (byte addresses on the wishbone slave)
`define FPA_OFS_CMD     8'h00
`define FPA_OFS_XOP     8'h04
`define FPA_OFS_YOP     8'h08
`define FPA_OFS_RES     8'h0C
`define FPA_OFS_EXT     8'h10
`define FPA_OFS_STAT    8'h14
`define FPA_OFS_MODE    8'h18

// command word fields
`define FPA_CMD_OP_LSB  0
`define FPA_CMD_CU_LSB  8
`define FPA_CU_ALU      2'h0
`define FPA_CU_MUL      2'h1
`define FPA_CU_SHF      2'h2

// status bit positions
`define FPA_ST_ZERO     0
`define FPA_ST_OVF      1
`define FPA_ST_NEG      2
`define FPA_ST_CARRY    3
`define FPA_ST_SIGN     4
`define FPA_ST_INV      5
`define FPA_ST_UNF      6
`define FPA_ST_REJ      8
`define FPA_ST_HIST_LSB 24

// mode bit positions
`define FPA_MODE_RND    0
`define FPA_MODE_SAT    1

// saturation limits and reset values
`define FPA_MAX_POS     32'h7FFFFFFF
`define FPA_MIN_NEG     32'h80000000
`define FPA_RST_WORD    32'h00000000
`define FPA_RST_EXT     8'h00

// operation codes
`define FPA_OP_ADD      8'h01
`define FPA_OP_SUB      8'h02
`define FPA_OP_ADDC     8'h05
`define FPA_OP_SUBB     8'h06
`define FPA_OP_AVG      8'h09
`define FPA_OP_COMP     8'h0A
`define FPA_OP_PASS     8'h21
`define FPA_OP_NEG      8'h22
`define FPA_OP_XCI      8'h25
`define FPA_OP_XCIM     8'h26
`define FPA_OP_INC      8'h29
`define FPA_OP_DEC      8'h2A
`define FPA_OP_ABS      8'h30
`define FPA_OP_AND      8'h40
`define FPA_OP_OR       8'h41
`define FPA_OP_XOR      8'h42
`define FPA_OP_NOT      8'h43
`define FPA_OP_MIN      8'h61
`define FPA_OP_MAX      8'h62
`define FPA_OP_CLIP     8'h63

`endif

/* rtl/fpa_pkg.sv */
// types shared by the fixed-point alu unit
package fpa_pkg;

  // flags produced by one alu operation
  typedef struct packed {
    logic zero;
    logic neg;
    logic ovf;
    logic carry;
  } fpa_flags_t;

  // result of one alu operation
  typedef struct packed {
    logic [31:0] value;
    fpa_flags_t  flags;
    logic        writes;   // destination is written
    logic        compare;  // shift the compare history
    logic        legal;    // code is a known fixed-point code
  } fpa_result_t;

  // bus slave phases
  typedef enum logic [2:0] {
    FPA_IDLE = 3'b001,
    FPA_ACK  = 3'b010,
    FPA_GAP  = 3'b100
  } fpa_bus_state_t;

endpackage : fpa_pkg

/* rtl/fpa_top.sv */
// fixed-point alu unit with a classic wishbone register slave
`timescale 1ns/1ps
`include "fpa_params.svh"

// How it works
// - unit select 00 goes to the alu, 01 multiplier, 10 shifter.
// - each alu operation is named by an eight-bit code in the command.
// - code 01 adds x and y fixed-point fields into the destination.
// - code 02 subtracts y from x into the destination.
// - add and subtract results clear the eight-bit extension field.
// - with saturation on, positive overflow gives 7FFFFFFF.
// - with saturation on, negative overflow gives 80000000.
// - zero flag set when the output is all zeros.
// - negative flag follows the output top bit.
// - overflow flag is xor of the top two adder carries.
// - carry flag is the carry out of the top adder stage.
// - two-operand add carry, subtract borrow, average and compare are decoded.
// - increment, decrement, abs, add carry, add borrow, negate, pass are decoded.
// - and, or, not and xor codes apply bitwise logic.
// - min, max and clip go to the comparison-select logic.
// - fixed and floating views share one 40-bit entry; only interpretation differs.
// - add carry adds the carry flag; subtract borrow adds carry minus one.
// - average halves the sum, rounding by mode bit, and clears overflow.
// - compare sets zero on equal, negative on x below y, writes nothing.
// - compare shifts the history in status 31:24 right, new greater-than on top.
module fpa_top (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // dispatch to the other units
  output logic             mul_req_o,
  output logic             shf_req_o,
  output logic      [7:0]  unit_op_o
);
  import fpa_pkg::*;

  // ==========================================================
  // registers
  // ==========================================================
  logic [31:0]    x_q;
  logic [31:0]    y_q;
  logic [31:0]    res_q;
  logic [7:0]     ext_q;
  logic [31:0]    stat_q;
  logic [1:0]     mode_q;
  fpa_bus_state_t st_q;
  fpa_result_t    alu;
  logic [7:0]     op;
  logic [1:0]     unit_select_field;
  logic           wr_go;
  logic           cmd_go;
  logic [31:0]    wmask;
  logic [31:0]    rdata;

  assign wr_go  = (st_q == FPA_IDLE) && cyc_i && stb_i && we_i;
  assign cmd_go = wr_go && (adr_i == `FPA_OFS_CMD) && sel_i[1] && sel_i[0];
  assign op                = dat_i[`FPA_CMD_OP_LSB +: 8];
  assign unit_select_field = dat_i[`FPA_CMD_CU_LSB +: 2];

  // byte enables expand to a bit mask
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_mask
      assign wmask[8*g +: 8] = {8{sel_i[g]}};
    end
  endgenerate

  // ==========================================================
  // datapath
  // ==========================================================
  fpa_core u_core (
    .op_i    (op),
    .x_i     (x_q),
    .y_i     (y_q),
    .sat_i   (mode_q[`FPA_MODE_SAT]),
    .rnd_i   (mode_q[`FPA_MODE_RND]),
    .carry_i (stat_q[`FPA_ST_CARRY]),
    .res_o   (alu)
  );

  // ==========================================================
  // bus handshake: one ack per request, then a gap cycle
  // ==========================================================
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q  <= FPA_IDLE;
      ack_o <= 1'b0;
    end else begin
      unique case (st_q)
        FPA_IDLE: begin
          if (cyc_i && stb_i) begin
            st_q  <= FPA_ACK;
            ack_o <= 1'b1;
          end
        end
        FPA_ACK: begin
          st_q  <= FPA_GAP;
          ack_o <= 1'b0;
        end
        FPA_GAP: st_q <= FPA_IDLE;
      endcase
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    unique case (adr_i)
      `FPA_OFS_XOP:  rdata = x_q;
      `FPA_OFS_YOP:  rdata = y_q;
      `FPA_OFS_RES:  rdata = res_q;
      `FPA_OFS_EXT:  rdata = {24'h000000, ext_q};
      `FPA_OFS_STAT: rdata = stat_q;
      `FPA_OFS_MODE: rdata = {30'h0, mode_q};
      default:       rdata = 32'h00000000;
    endcase
  end

  // read data is captured with the ack so it stands in the ack cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) dat_o <= 32'h00000000;
    else if ((st_q == FPA_IDLE) && cyc_i && stb_i && !we_i) dat_o <= rdata;
  end

  // ==========================================================
  // operand and mode registers
  // ==========================================================
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      x_q    <= `FPA_RST_WORD;
      y_q    <= `FPA_RST_WORD;
      mode_q <= 2'h0;
    end else if (wr_go) begin
      if (adr_i == `FPA_OFS_XOP) x_q <= (x_q & ~wmask) | (dat_i & wmask);
      if (adr_i == `FPA_OFS_YOP) y_q <= (y_q & ~wmask) | (dat_i & wmask);
      if (adr_i == `FPA_OFS_MODE && sel_i[0]) mode_q <= dat_i[1:0];
    end
  end

  // ==========================================================
  // destination register: 32-bit field plus 8-bit extension
  // ==========================================================
  // both halves form one 40-bit entry; an alu write loads bits 39:8 and clears bits 7:0
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      res_q <= `FPA_RST_WORD;
      ext_q <= `FPA_RST_EXT;
    end else if (cmd_go && unit_select_field == `FPA_CU_ALU && alu.writes) begin
      res_q <= alu.value;
      ext_q <= `FPA_RST_EXT;
    end else if (wr_go && adr_i == `FPA_OFS_RES) begin
      res_q <= (res_q & ~wmask) | (dat_i & wmask);
    end else if (wr_go && adr_i == `FPA_OFS_EXT && sel_i[0]) begin
      ext_q <= dat_i[7:0];
    end
  end

  // ==========================================================
  // status flags and compare history
  // ==========================================================
  // illegal codes leave the flags alone and raise a sticky reject bit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat_q <= `FPA_RST_WORD;
    end else if (cmd_go && unit_select_field == `FPA_CU_ALU) begin
      if (alu.legal) begin
        stat_q[`FPA_ST_ZERO]  <= alu.flags.zero;
        stat_q[`FPA_ST_NEG]   <= alu.flags.neg;
        stat_q[`FPA_ST_OVF]   <= alu.flags.ovf;
        stat_q[`FPA_ST_CARRY] <= alu.flags.carry;
        stat_q[`FPA_ST_UNF]   <= 1'b0;
        stat_q[`FPA_ST_SIGN]  <= 1'b0;
        stat_q[`FPA_ST_INV]   <= 1'b0;
        if (alu.compare)
          stat_q[31:24] <= {~alu.flags.zero & ~alu.flags.neg,
                            stat_q[31:25]};
      end else begin
        stat_q[`FPA_ST_REJ] <= 1'b1;
      end
    end else if (wr_go && adr_i == `FPA_OFS_STAT) begin
      // software may restore the status word, e.g. to seed the carry
      stat_q <= (stat_q & ~wmask) | (dat_i & wmask);
    end
  end

  // ==========================================================
  // dispatch of non-alu unit selects
  // ==========================================================
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mul_req_o <= 1'b0;
      shf_req_o <= 1'b0;
      unit_op_o <= 8'h00;
    end else begin
      mul_req_o <= cmd_go && unit_select_field == `FPA_CU_MUL;
      shf_req_o <= cmd_go && unit_select_field == `FPA_CU_SHF;
      if (cmd_go) unit_op_o <= op;
    end
  end

  // ==========================================================
  // checks
  // ==========================================================
  logic cmd_alu;
  assign cmd_alu = cmd_go && unit_select_field == `FPA_CU_ALU;

  a_add_result: assert property (@(posedge clk_i) disable iff (rst_i)
    cmd_alu && op == `FPA_OP_ADD && !mode_q[`FPA_MODE_SAT] |=> res_q == $past(x_q) + $past(y_q))
    else $error("add result wrong");
  a_sub_result: assert property (@(posedge clk_i) disable iff (rst_i)
    cmd_alu && op == `FPA_OP_SUB && !mode_q[`FPA_MODE_SAT] |=> res_q == $past(x_q) - $past(y_q))
    else $error("sub result wrong");
  a_ext_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    cmd_alu && alu.writes |=> ext_q == 8'h00)
    else $error("extension not cleared");
  a_sat_pos: assert property (@(posedge clk_i) disable iff (rst_i)
    cmd_alu && op == `FPA_OP_ADD && mode_q[`FPA_MODE_SAT] && !x_q[31] && !y_q[31]
      && alu.flags.ovf |=> res_q == 32'h7FFFFFFF)
    else $error("positive saturation missing");
  a_sat_neg: assert property (@(posedge clk_i) disable iff (rst_i)
    cmd_alu && op == `FPA_OP_ADD && mode_q[`FPA_MODE_SAT] && x_q[31] && y_q[31]
      && alu.flags.ovf |=> res_q == 32'h80000000)
    else $error("negative saturation missing");
  a_zero_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    cmd_alu && (op == `FPA_OP_ADD || op == `FPA_OP_SUB) |=> stat_q[0] == (res_q == 32'h0))
    else $error("zero flag wrong");
  a_neg_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    cmd_alu && (op == `FPA_OP_ADD || op == `FPA_OP_SUB) |=> stat_q[2] == res_q[31])
    else $error("negative flag wrong");
  a_flags_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    cmd_alu && alu.legal |=> stat_q[6:4] == 3'b000)
    else $error("aux flags not cleared");
  a_comp_nowrite: assert property (@(posedge clk_i) disable iff (rst_i)
    cmd_alu && op == `FPA_OP_COMP |=> $stable(res_q))
    else $error("compare wrote result");
  a_hist_shift: assert property (@(posedge clk_i) disable iff (rst_i)
    cmd_alu && op == `FPA_OP_COMP |=> stat_q[30:24] == $past(stat_q[31:25]))
    else $error("history not shifted");
  a_mul_route: assert property (@(posedge clk_i) disable iff (rst_i)
    cmd_go && unit_select_field == `FPA_CU_MUL |=> mul_req_o && !shf_req_o ##1 !mul_req_o)
    else $error("multiplier dispatch wrong");
  a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o ##1 !ack_o)
    else $error("ack longer than a cycle");

  c_add: cover property (@(posedge clk_i) cmd_alu && op == `FPA_OP_ADD);
  c_sat: cover property (@(posedge clk_i) cmd_alu && mode_q[1] && alu.flags.ovf);
  c_comp: cover property (@(posedge clk_i) cmd_alu && op == `FPA_OP_COMP);
  c_shift_route: cover property (@(posedge clk_i) shf_req_o);

endmodule : fpa_top
